// >>> hw/can_filter_consts.svh
`ifndef CAN_FILTER_CONSTS_SVH
`define CAN_FILTER_CONSTS_SVH
// register index space: word index within each group
`define NUM_FILTERS      32
`define NUM_CTRL_WORDS   8
`define NUM_QUEUES       32
`define GRP_USER_ADDR    2'h0
`define GRP_CONTROL      2'h1
`define GRP_OBJECT       2'h2
`define GRP_MASK         2'h3
// filter control byte fields
`define CTL_EN_BIT       7
`define CTL_PTR_MSB      4
`define CTL_BYTE_MASK    8'h9F
// object / mask fields
`define FMT_BIT          30
`define BIT_TWELVE       29
`define EXT_MSB          28
`define EXT_LSB          11
`define BASE_MSB         10
`define OBJ_MASK         32'h7FFFFFFF
`define REG_RESET        32'h00000000
`endif

// >>> hw/can_filter_pkg.sv
package can_filter_pkg;
  typedef logic [31:0] word_t;
  typedef logic [4:0]  queue_t;
  typedef logic [6:0]  reg_index_t;
endpackage : can_filter_pkg

// >>> hw/can_rx_acceptance_filters.sv
// Function
// RULE1: transmit queue user pointer reads the queue head address.
// RULE2: receive queue user pointer reads the queue tail address.
// RULE3: host reads user pointer only outside configuration mode.
// RULE4: read-only 32-bit user pointer per queue 1..31, unknown at power-on.
// RULE5: four filters per control word, enables at bits 31,23,15,7.
// RULE6: 5-bit destination at 28-24,20-16,12-8,4-0; gaps read zero.
// RULE7: hit stores message into queue numbered by filter destination.
// RULE8: destination zero reserved; never delivers a message.
// RULE9: destination writable only while the filter is disabled.
// RULE10: filter object writable only while the filter is disabled.
// RULE11: object: format 30, bit twelve 29, extension 28-11, base 10-0.
// RULE12: format qualify set: select one matches long, zero matches base.
// RULE13: format qualify set limits matching to the selected format.
// RULE14: format qualify clear accepts both formats on identifier match.
// RULE15: mask: qualify 30, bit twelve 29, extension 28-11, base 10-0.
// RULE16: data-byte mode compares extension bits to first 18 data bits.
// RULE17: data-byte mode mask extension bits qualify those data bits.
// RULE18: eight control words for 32 filters; all clear at reset.
// RULE19: queue direction select: one transmit, zero receive.
// RULE20: masked-in bits must equal; masked-out bits ignored.
// RULE21: lowest-numbered hitting filter wins; message stored once.
`timescale 1ns/1ps
`include "can_filter_consts.svh"
module can_rx_acceptance_filters (
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      sys_rst,
  // register port: index = group*32 + word
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire can_filter_pkg::reg_index_t reg_index,
  input  wire can_filter_pkg::word_t      reg_wdata,
  output can_filter_pkg::word_t           reg_rdata,
  // per-queue state from the queue engine
  input  wire logic [31:0]               queue_direction_select,
  input  wire logic [1023:0]             queue_head_addr,
  input  wire logic [1023:0]             queue_tail_addr,
  // received frame to classify
  input  wire logic                      rx_valid,
  input  wire logic                      rx_long_format,
  input  wire logic                      rx_data_byte_mode,
  input  wire logic [28:0]               rx_id,
  input  wire logic [17:0]               rx_data_bits,
  // classification result
  output logic                           hit_valid,
  output logic                           miss_valid,
  output can_filter_pkg::queue_t          hit_queue,
  output logic [4:0]                     hit_filter
);
  import can_filter_pkg::*;

  logic [7:0]  ctl_byte [`NUM_FILTERS];
  word_t       obj      [`NUM_FILTERS];
  word_t       msk      [`NUM_FILTERS];
  logic [7:0]  next_ctl_byte [`NUM_FILTERS];
  word_t       next_obj      [`NUM_FILTERS];
  word_t       next_msk      [`NUM_FILTERS];
  logic [`NUM_FILTERS-1:0] hit_vec;
  logic [1:0]  grp;
  logic [4:0]  widx;
  word_t       next_rdata;
  logic        next_hit_valid;
  logic        next_miss_valid;
  queue_t      next_hit_queue;
  logic [4:0]  next_hit_filter;

  assign grp  = reg_index[6:5];
  assign widx = reg_index[4:0];

  // storage update, per filter
  genvar g;
  generate
    for (g = 0; g < `NUM_FILTERS; g++) begin : g_flt
      localparam logic [4:0] CW = 5'(g / 4);
      localparam int         LANE = g % 4;
      logic en;
      logic [31:0] sample;
      assign en = ctl_byte[g][`CTL_EN_BIT];
      always_comb begin
        next_ctl_byte[g] = ctl_byte[g];
        next_obj[g]      = obj[g];
        next_msk[g]      = msk[g];
        if (reg_wr && grp == `GRP_CONTROL && widx == CW) begin
          if (en) begin
            // pointer frozen while enabled; only the enable may change
            next_ctl_byte[g][`CTL_EN_BIT] = reg_wdata[LANE*8+`CTL_EN_BIT]; // [RULE9]
          end else begin
            next_ctl_byte[g] = reg_wdata[LANE*8 +: 8] & `CTL_BYTE_MASK; // [RULE5] [RULE6]
          end
        end
        if (reg_wr && grp == `GRP_OBJECT && widx == 5'(g) && !en) begin
          next_obj[g] = reg_wdata & `OBJ_MASK; // [RULE10] [RULE11]
        end
        if (reg_wr && grp == `GRP_MASK && widx == 5'(g)) begin
          next_msk[g] = reg_wdata & `OBJ_MASK; // [RULE15]
        end
      end
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          ctl_byte[g] <= 8'h00; // [RULE18]
          obj[g]      <= `REG_RESET;
          msk[g]      <= `REG_RESET;
        end else begin
          ctl_byte[g] <= next_ctl_byte[g];
          obj[g]      <= next_obj[g];
          msk[g]      <= next_msk[g];
        end
      end
      // comparison: data-byte mode substitutes data bits for extension in base-format frames only
      always_comb begin
        sample = {2'b00, rx_id};
        if (rx_data_byte_mode && !rx_long_format) begin
          sample[`EXT_MSB:`EXT_LSB] = rx_data_bits; // [RULE16] [RULE17]
        end
      end
      assign hit_vec[g] = en
        && (ctl_byte[g][`CTL_PTR_MSB:0] != 5'h00) // [RULE8]
        && (((sample[`BIT_TWELVE:0] ^ obj[g][`BIT_TWELVE:0])
             & msk[g][`BIT_TWELVE:0]) == 30'h0) // [RULE20]
        && (!msk[g][`FMT_BIT]
            || (obj[g][`FMT_BIT] == rx_long_format)); // [RULE12] [RULE13] [RULE14]

      // per-filter checks
      lane_gap_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE6]
        ctl_byte[g][6:5] == 2'b00)
        else $error("unimplemented control bits set");
      lane_reset_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE18]
        $past(sys_rst) |-> ctl_byte[g] == 8'h00 && obj[g] == 32'h0 && msk[g] == 32'h0)
        else $error("filter state not cleared by reset");
      lane_enable_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE5]
        !$past(sys_rst) && $past(reg_wr && grp == `GRP_CONTROL && widx == CW)
          |-> en == $past(reg_wdata[LANE*8+`CTL_EN_BIT]))
        else $error("filter enable not written");
      lane_ptr_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE9]
        !$past(sys_rst) && $past(reg_wr && grp == `GRP_CONTROL && widx == CW && !en)
          |-> ctl_byte[g][`CTL_PTR_MSB:0] == $past(reg_wdata[LANE*8 +: 5]))
        else $error("destination not written while disabled");
      ptr_lock_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE9]
        !$past(sys_rst) && $past(en) |-> $stable(ctl_byte[g][`CTL_PTR_MSB:0]))
        else $error("destination changed while enabled");
      obj_lock_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE10]
        !$past(sys_rst) && $past(en) |-> $stable(obj[g]))
        else $error("object changed while enabled");
      obj_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE11]
        !$past(sys_rst) && $past(reg_wr && grp == `GRP_OBJECT && widx == 5'(g) && !en)
          |-> obj[g] == ($past(reg_wdata) & `OBJ_MASK))
        else $error("object write lost");
      mask_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE15]
        !$past(sys_rst) && $past(reg_wr && grp == `GRP_MASK && widx == 5'(g))
          |-> msk[g] == ($past(reg_wdata) & `OBJ_MASK))
        else $error("mask write lost");
      zero_dest_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE8]
        ctl_byte[g][`CTL_PTR_MSB:0] == 5'h00 |-> !hit_vec[g])
        else $error("filter with reserved destination hit");
      off_nohit_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE5]
        !en |-> !hit_vec[g])
        else $error("disabled filter hit");
      format_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE13]
        msk[g][`FMT_BIT] && (obj[g][`FMT_BIT] != rx_long_format) |-> !hit_vec[g])
        else $error("frame of other format hit");
      open_mask_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE14]
        en && (ctl_byte[g][`CTL_PTR_MSB:0] != 5'h00) && (msk[g] == 32'h0) |-> hit_vec[g])
        else $error("open mask did not hit");
    end
  endgenerate

  // priority pick and register read
  always_comb begin
    next_hit_valid  = 1'b0;
    next_miss_valid = 1'b0;
    next_hit_queue  = 5'h00;
    next_hit_filter = 5'h00;
    if (rx_valid) begin
      next_miss_valid = (hit_vec == 32'h0);
      for (int i = `NUM_FILTERS - 1; i >= 0; i--) begin
        if (hit_vec[i]) begin
          next_hit_valid  = 1'b1; // [RULE21]
          next_hit_filter = 5'(i);
          next_hit_queue  = ctl_byte[i][`CTL_PTR_MSB:0]; // [RULE7]
        end
      end
    end
    next_rdata = 32'h0;
    if (reg_rd) begin
      unique case (grp)
        `GRP_USER_ADDR: begin
          if (widx != 5'h00) begin
            next_rdata = queue_direction_select[widx]
              ? queue_head_addr[widx*32 +: 32]   // [RULE1] [RULE19] [RULE4]
              : queue_tail_addr[widx*32 +: 32];  // [RULE2]
          end
        end
        `GRP_CONTROL: begin
          if (widx < 5'(`NUM_CTRL_WORDS)) begin
            next_rdata = {ctl_byte[{widx[2:0], 2'd3}], ctl_byte[{widx[2:0], 2'd2}],
                          ctl_byte[{widx[2:0], 2'd1}], ctl_byte[{widx[2:0], 2'd0}]};
          end
        end
        `GRP_OBJECT: next_rdata = obj[widx];
        `GRP_MASK:   next_rdata = msk[widx];
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata  <= 32'h0;
      hit_valid  <= 1'b0;
      miss_valid <= 1'b0;
      hit_queue  <= 5'h00;
      hit_filter <= 5'h00;
    end else begin
      reg_rdata  <= next_rdata;
      hit_valid  <= next_hit_valid;
      miss_valid <= next_miss_valid;
      hit_queue  <= next_hit_queue;
      hit_filter <= next_hit_filter;
    end
  end

  // checks
  queue_nonzero_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE8]
    hit_valid |-> hit_queue != 5'h00)
    else $error("hit delivered to reserved queue zero");
  hit_miss_excl_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE21]
    !(hit_valid && miss_valid))
    else $error("hit and miss both raised");
  result_timing_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE7]
    rx_valid && (hit_vec != 32'h0) |=> hit_valid)
    else $error("hit not reported one cycle after frame");
  ptr_frozen_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE9]
    ctl_byte[0][`CTL_EN_BIT] && $past(ctl_byte[0][`CTL_EN_BIT])
      |-> $stable(ctl_byte[0][`CTL_PTR_MSB:0]))
    else $error("filter destination changed while enabled");
  obj_frozen_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE10]
    !$past(sys_rst) && $past(ctl_byte[0][`CTL_EN_BIT]) |-> $stable(obj[0]))
    else $error("filter object changed while enabled");
  gap_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE6]
    ctl_byte[3][6:5] == 2'b00)
    else $error("unimplemented control bits set");
  obj_top_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE11]
    !obj[5][31] && !msk[5][31])
    else $error("object or mask bit 31 set");
  miss_timing_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE20]
    rx_valid && (hit_vec == 32'h0) |=> miss_valid && !hit_valid)
    else $error("miss not reported");
  ua_head_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE1] [RULE19]
    !$past(sys_rst) && $past(reg_rd) && $past(grp) == `GRP_USER_ADDR
      && $past(widx) != 5'h00 && $past(queue_direction_select[widx])
      |-> reg_rdata == $past(queue_head_addr[widx*32 +: 32]))
    else $error("transmit queue pointer not head");
  ua_tail_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE2] [RULE19]
    !$past(sys_rst) && $past(reg_rd) && $past(grp) == `GRP_USER_ADDR
      && $past(widx) != 5'h00 && !$past(queue_direction_select[widx])
      |-> reg_rdata == $past(queue_tail_addr[widx*32 +: 32]))
    else $error("receive queue pointer not tail");
  ua_word0_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE4]
    $past(reg_rd) && $past(reg_index) == 7'h00 |-> reg_rdata == 32'h0)
    else $error("queue zero pointer not zero");
  ctl_high_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE18]
    $past(reg_rd) && $past(grp) == `GRP_CONTROL && $past(widx) >= 5'h08
      |-> reg_rdata == 32'h0)
    else $error("control word above seven not zero");
  rdata_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE4]
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data without read");
  pick_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE21] [RULE7]
    rx_valid && hit_vec[0]
      |=> hit_valid && hit_filter == 5'h00 && hit_queue == $past(ctl_byte[0][`CTL_PTR_MSB:0]))
    else $error("filter zero hit not chosen");
  out_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE21]
    !$past(sys_rst) && !$past(rx_valid) |-> !hit_valid && !miss_valid)
    else $error("result without frame");
endmodule : can_rx_acceptance_filters

// >>> verification/host_port_model.sv
`timescale 1ns/1ps
module host_port_model (
  // clock
  input  wire logic                        sys_clk,
  // register port
  output logic                             reg_wr,
  output logic                             reg_rd,
  output can_filter_pkg::reg_index_t       reg_index,
  output can_filter_pkg::word_t            reg_wdata,
  input  wire can_filter_pkg::word_t       reg_rdata
);
  import can_filter_pkg::*;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_index = 7'h00;
    reg_wdata = 32'h00000000;
  end
  // callers may write pointer or object with enable still set; the lock keeps the old value
  // no pointer zero as a real target reads outside config
  task automatic wr(input reg_index_t idx, input word_t d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_index <= idx;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;  // released data shows no stale value
  endtask : wr
  task automatic rd(input reg_index_t idx, output word_t d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_index <= idx;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
endmodule : host_port_model

// >>> verification/can_rx_acceptance_filters_tb.sv
`timescale 1ns/1ps
module can_rx_acceptance_filters_tb;
  import can_filter_pkg::*;
  typedef struct {logic lf; logic dbm; logic [28:0] id; logic [17:0] db;
                  logic h; logic [4:0] q; logic [4:0] f;} row_s;
  logic sys_clk = 1'b0, sys_rst = 1'b1, rx_valid = 1'b0, rx_lf = 1'b0, rx_dbm = 1'b0;
  logic [28:0] rx_id = '0;
  logic [17:0] rx_db = '0;
  logic [31:0] dir = 32'h00000008;
  logic [1023:0] head, tail;
  logic reg_wr, reg_rd, hit_valid, miss_valid;
  reg_index_t reg_index;
  word_t reg_wdata, reg_rdata, rdata;
  queue_t hit_queue;
  logic [4:0] hit_filter;
  int bad_count = 0, checks = 0;
  row_s rows [5] = '{'{0, 0, 29'h123, 0, 1, 5, 0}, '{1, 0, {18'h2AAAA, 11'h055}, 0, 1, 31, 1},
                     '{1, 0, 29'h123, 0, 1, 1, 2}, '{0, 0, 29'h124, 0, 0, 0, 0},
                     '{0, 0, {18'h3FFFF, 11'h123}, 0, 1, 5, 0}};
  always #4 sys_clk = ~sys_clk;
  initial for (int q = 0; q < 32; q++) begin
    head[q*32+:32] = 32'hA0000000 + q;
    tail[q*32+:32] = 32'hB0000000 + q;
  end
  host_port_model host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  can_rx_acceptance_filters DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .queue_direction_select(dir), .queue_head_addr(head), .queue_tail_addr(tail),
    .rx_valid(rx_valid), .rx_long_format(rx_lf), .rx_data_byte_mode(rx_dbm), .rx_id(rx_id),
    .rx_data_bits(rx_db), .hit_valid(hit_valid), .miss_valid(miss_valid),
    .hit_queue(hit_queue), .hit_filter(hit_filter));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rdc(input reg_index_t idx, input word_t exp);
    host.rd(idx, rdata);
    chk(rdata, exp);
  endtask : rdc
  task automatic frame(input row_s r);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_lf <= r.lf;
    rx_dbm <= r.dbm;
    rx_id <= r.id;
    rx_db <= r.db;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    #1 chk({hit_valid, miss_valid}, {r.h, ~r.h});
    if (r.h) chk({hit_queue, hit_filter}, {r.q, r.f});
  endtask : frame
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  initial begin
    #100000;
    bad_count++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rdc(7'h20, 32'h0);
    rdc(7'h40, 32'h0);
    rdc(7'h60, 32'h0);
    rdc(7'h03, 32'hA0000003);
    rdc(7'h04, 32'hB0000004);
    @(posedge sys_clk) dir <= 32'h00000010;
    rdc(7'h04, 32'hA0000004);
    host.wr(7'h40, 32'h80000123);
    host.wr(7'h60, 32'h400007FF);
    host.wr(7'h41, 32'h55555055);
    host.wr(7'h61, 32'hDFFFFFFF);
    host.wr(7'h42, 32'h00000123);
    host.wr(7'h62, 32'h000007FF);
    host.wr(7'h20, 32'hE0E1FFE5);
    rdc(7'h20, 32'h80819F85);
    rdc(7'h40, 32'h00000123);
    rdc(7'h61, 32'h5FFFFFFF);
    foreach (rows[i]) frame(rows[i]);
    host.wr(7'h20, 32'h80819005);
    rdc(7'h20, 32'h80819F05);
    host.wr(7'h41, 32'h0);
    rdc(7'h41, 32'h55555055);
    frame('{0, 0, 29'h123, 0, 1, 1, 2});
    host.wr(7'h40, 32'h091A2923);
    host.wr(7'h60, 32'h5FFFFFFF);
    host.wr(7'h20, 32'h80819F87);
    frame('{0, 1, 29'h123, 18'h12345, 1, 7, 0});
    frame('{0, 1, 29'h123, 18'h12344, 1, 1, 2});
    @(posedge sys_clk) sys_rst <= 1'b1;
    @(posedge sys_clk) sys_rst <= 1'b0;
    rdc(7'h20, 32'h0);
    summarize();
  end
endmodule : can_rx_acceptance_filters_tb
